/* File: rtl/dfs_driver_fault_supervisor.sv */
/*
  dfs_driver_fault_supervisor: fault supervision for an eight-channel driver.
  Holds the serial receiver (on the serial clock), the command register, the
  fault filters and latches, and the drive outputs (on clk_sys).
  Assumes: sensor flags are synchronous to clk_sys; the host holds the serial
  clock low around chip select edges and keeps it still while chip select is high.
*/
`timescale 1ns/1ps

// Functional notes
// - confirmed over-current latches the channel off; no self retry until cleared
// - over-current is only evaluated while the channel is driven on
// - channels form four thermal pairs, each with warning and shutdown flags
// - status bit 0 shows thermal warning; outputs stay on for warning only
// - overtemperature faults both channels of the pair and shuts the pair off
// - overtemperature latch holds after the temperature flag drops
// - chip select falling drives thermal warning onto serial output without clock
// - logic supply undervoltage turns outputs off, clears command and status
// - load supply undervoltage shuts all channels and latches status bit 15
// - after load supply recovers channels return to their commanded state
// - serial port keeps working during load supply faults
// - supply-fail bit clears on a valid frame with the load supply in range
// - load overvoltage turns outputs off, latches bit 15, keeps registers intact
// - open-load diagnostics only on off channels whose bits 8 to 15 enable them
// - diagnostics suppressed on load supply fault or enable low; off after reset
// - enable pin low resets all logic and turns all outputs off
// - enable high accepts commands including parallel inputs of upper channels
// - open load is live status, never shown for a channel that is on
// - open load captured only if present at chip select fall, channel fully off
// - over-current latches after persisting for the 100 us filter time
// - a valid frame with enable bit 0 clears the over-current latch
// - only frames of a multiple of 16 bits load the command register
// - command bits 0 to 7 switch each channel on (1) or off (0)
// - each channel has one filter timer for over-current and open load
// - channels 5 to 8 are on when serial bit or parallel input is high
module dfs_driver_fault_supervisor
  import dfs_pkg::*;
#(
  parameter int FILTER_CYCLES = DFS_FILT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEnable,
  input wire logic serialClk,
  input wire logic chipSelect_n,
  input wire logic serialIn,
  output logic serialOutData,
  output logic serialOutEnable,
  input wire logic enablePin,
  input wire logic [DFS_PWM_INPUTS-1:0] parallelIn,
  input wire logic logicSupplyUv,
  input wire logic loadSupplyUv,
  input wire logic loadSupplyOv,
  input wire logic [DFS_PAIRS-1:0] thermalWarnFlag,
  input wire logic [DFS_PAIRS-1:0] thermalShutFlag,
  input wire logic [DFS_CHANNELS-1:0] overCurrentFlag,
  input wire logic [DFS_CHANNELS-1:0] openLoadFlag,
  output logic [DFS_CHANNELS-1:0] driveOut,
  output logic [DFS_CHANNELS-1:0] diagSourceEnable,
  output logic supplyFail
);

  // link domain (serial clock)
  logic [15:0] rxShift_reg;
  logic [3:0] bitCnt_reg;
  logic anyBit_reg;
  logic frameOk_reg;
  logic [3:0] txIdx_reg;

  // system domain
  logic [2:0] csSync_reg;
  logic [1:0] enSync_reg;
  logic [DFS_PWM_INPUTS-1:0] inMeta_reg;
  logic [DFS_PWM_INPUTS-1:0] inSync_reg;
  logic frameValid_reg;
  logic [15:0] frame_reg;
  logic [15:0] cmd_reg;
  logic [15:0] statusSnap_reg;
  logic [DFS_CHANNELS-1:0] ocLatch_reg;
  logic [DFS_PAIRS-1:0] otLatch_reg;
  logic psFail_reg;
  logic [DFS_PWM_INPUTS-1:0] inRecord_reg;
  logic [DFS_CHANNELS-1:0] driveOut_reg;
  logic [DFS_CHANNELS-1:0] diagEn_reg;
  logic [DFS_CHANNELS-1:0] ocQual;
  logic [DFS_CHANNELS-1:0] olQual;

  logic softClear;
  logic vsFault;
  logic csRise;
  logic csHigh;
  logic [DFS_CHANNELS-1:0] parMap;
  logic [DFS_CHANNELS-1:0] cmdOn;
  logic [DFS_CHANNELS-1:0] otByCh;
  logic [DFS_CHANNELS-1:0] driveNext;
  logic [DFS_CHANNELS-1:0] diagNext;
  logic [DFS_CHANNELS-1:0] olLive;
  logic [15:0] statusNext;

  // serial receiver: counter cleared whenever chip select is high
  always_ff @(posedge serialClk or posedge chipSelect_n) begin
    if (chipSelect_n) begin
      bitCnt_reg <= 4'h0;
      anyBit_reg <= 1'b0;
    end else begin
      bitCnt_reg <= bitCnt_reg + 4'h1;
      anyBit_reg <= 1'b1;
    end
  end

  // frame length judged at the chip select rise itself; the counter clears on
  // that same edge, so the verdict must be taken here, not later in clk_sys
  always_ff @(posedge chipSelect_n) begin
    frameOk_reg <= anyBit_reg & (bitCnt_reg == 4'h0);
  end

  // data shifts in lsb first; after n*16 bits the last word sits here
  always_ff @(posedge serialClk) begin
    rxShift_reg <= {serialIn, rxShift_reg[15:1]};
  end

  // transmit index moves on the falling edge so the host samples stable data
  always_ff @(negedge serialClk or posedge chipSelect_n) begin
    if (chipSelect_n) begin
      txIdx_reg <= 4'h0;
    end else begin
      txIdx_reg <= txIdx_reg + 4'h1;
    end
  end

  // bit 0 (thermal warning) is on the line as soon as chip select falls
  assign serialOutData = statusSnap_reg[txIdx_reg];
  assign serialOutEnable = ~chipSelect_n;

  // pin synchronisers; only the second stage onward is read
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      csSync_reg <= 3'h7;
      enSync_reg <= 2'h0;
      inMeta_reg <= '0;
      inSync_reg <= '0;
    end else if (clkEnable) begin
      csSync_reg <= {csSync_reg[1:0], chipSelect_n};
      enSync_reg <= {enSync_reg[0], enablePin};
      inMeta_reg <= parallelIn;
      inSync_reg <= inMeta_reg;
    end
  end

  assign csHigh = csSync_reg[1];
  assign csRise = csSync_reg[1] & ~csSync_reg[2];
  // enable low acts as power-on reset; logic supply undervoltage clears too
  assign softClear = ~enSync_reg[1] | logicSupplyUv;
  assign vsFault = loadSupplyUv | loadSupplyOv;

  // frame check: receiver state is still while chip select is high, so
  // it is read directly at the synchronised rising edge (csRise)
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frameValid_reg <= 1'b0;
      frame_reg <= DFS_CMD_RESET;
    end else if (clkEnable) begin
      frameValid_reg <= csRise & frameOk_reg & ~softClear;
      if (csRise) begin
        frame_reg <= rxShift_reg;
      end
    end
  end

  // command register; kept through load supply faults
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmd_reg <= DFS_CMD_RESET;
    end else if (clkEnable) begin
      if (softClear) begin
        cmd_reg <= DFS_CMD_RESET;
      end else if (frameValid_reg) begin
        cmd_reg <= frame_reg;
      end
    end
  end

  // parallel inputs or'd into the upper four channels
  always_comb begin
    parMap = '0;
    parMap[DFS_PWM_FIRST_CH +: DFS_PWM_INPUTS] = inSync_reg & {DFS_PWM_INPUTS{enSync_reg[1]}};
  end
  assign cmdOn = cmd_reg[DFS_CMD_EN_LSB +: DFS_CHANNELS] | parMap;

  // each thermal pair shares one latch
  genvar gp;
  generate
    for (gp = 0; gp < DFS_PAIRS; gp++) begin : g_pair
      assign otByCh[2*gp +: 2] = {2{otLatch_reg[gp]}};
    end
  endgenerate

  // drive: off on any latch, load supply fault or logic reset; once the
  // load supply is back the channel follows the command again
  assign driveNext = cmdOn & ~ocLatch_reg & ~otByCh & {DFS_CHANNELS{~vsFault & ~softClear}};
  // diagnostic sources only on off channels; reset leaves enable bits zero
  assign diagNext = ~driveNext & cmd_reg[DFS_CMD_OL_LSB +: DFS_CHANNELS]
                    & {DFS_CHANNELS{~vsFault & ~softClear}};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      driveOut_reg <= '0;
      diagEn_reg <= '0;
    end else if (clkEnable) begin
      driveOut_reg <= driveNext;
      diagEn_reg <= diagNext;
    end
  end

  // one filter timer per channel, shared by over-current and open load;
  // a dropout restarts it, so pwm periods under the filter time never qualify
  genvar gc;
  generate
    for (gc = 0; gc < DFS_CHANNELS; gc++) begin : g_filt
      logic [DFS_FILT_W-1:0] filtCnt_reg;
      logic cond;
      // over-current only looked at while driven, open load only while off
      assign cond = driveOut_reg[gc] ? overCurrentFlag[gc]
                    : (diagEn_reg[gc] & openLoadFlag[gc]);
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          filtCnt_reg <= '0;
        end else if (clkEnable) begin
          if (!cond || softClear || (driveOut_reg[gc] != driveNext[gc])) begin
            filtCnt_reg <= '0;
          end else if (filtCnt_reg != FILTER_CYCLES[DFS_FILT_W-1:0]) begin
            filtCnt_reg <= filtCnt_reg + 1'b1;
          end
        end
      end
      assign ocQual[gc] = driveOut_reg[gc] & cond
                          & (filtCnt_reg == FILTER_CYCLES[DFS_FILT_W-1:0]);
      assign olQual[gc] = ~driveOut_reg[gc] & cond
                          & (filtCnt_reg == FILTER_CYCLES[DFS_FILT_W-1:0]);
    end
  endgenerate

  // over-current latch: set wins over the clearing frame
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ocLatch_reg <= '0;
    end else if (clkEnable) begin
      if (softClear) begin
        ocLatch_reg <= '0;
      end else begin
        ocLatch_reg <= ocQual | (ocLatch_reg & ~({DFS_CHANNELS{frameValid_reg}}
                       & ~frame_reg[DFS_CMD_EN_LSB +: DFS_CHANNELS]));
      end
    end
  end

  // overtemperature latch: clears only once the flag is gone and a valid
  // frame disables both channels of the pair
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      otLatch_reg <= '0;
    end else if (clkEnable) begin
      if (softClear) begin
        otLatch_reg <= '0;
      end else begin
        for (int p = 0; p < DFS_PAIRS; p++) begin
          if (thermalShutFlag[p]) begin
            otLatch_reg[p] <= 1'b1;
          end else if (frameValid_reg && (frame_reg[2*p +: 2] == 2'b00)) begin
            otLatch_reg[p] <= 1'b0;
          end
        end
      end
    end
  end

  // supply-fail latch; a frame during the fault does not clear it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      psFail_reg <= 1'b0;
    end else if (clkEnable) begin
      if (softClear) begin
        psFail_reg <= 1'b0;
      end else if (vsFault) begin
        psFail_reg <= 1'b1;
      end else if (frameValid_reg) begin
        psFail_reg <= 1'b0;
      end
    end
  end

  // parallel input mirror, frozen while a channel latch is set
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      inRecord_reg <= '0;
    end else if (clkEnable) begin
      if (softClear) begin
        inRecord_reg <= '0;
      end else if ((ocLatch_reg == '0) && (otLatch_reg == '0)) begin
        inRecord_reg <= inSync_reg;
      end
    end
  end

  // open load is live and only for a channel fully off by both paths
  assign olLive = olQual & ~cmdOn;

  always_comb begin
    statusNext = DFS_STAT_RESET;
    statusNext[DFS_STAT_TW] = |thermalWarnFlag;
    statusNext[DFS_STAT_CH_LSB +: DFS_CHANNELS] = ocLatch_reg | otByCh | olLive;
    statusNext[DFS_STAT_IN_LSB +: DFS_PWM_INPUTS] = inRecord_reg;
    statusNext[DFS_STAT_PSF] = psFail_reg;
  end

  // status snapshot follows live state while chip select is high and
  // freezes at its fall, which is where open load gets captured
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      statusSnap_reg <= DFS_STAT_RESET;
    end else if (clkEnable) begin
      if (softClear) begin
        statusSnap_reg <= DFS_STAT_RESET;
      end else if (csHigh) begin
        statusSnap_reg <= statusNext;
      end
    end
  end

  assign driveOut = driveOut_reg;
  assign diagSourceEnable = diagEn_reg;
  assign supplyFail = psFail_reg;

  // checks
  a_oc_latch_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEnable && (ocLatch_reg != '0) |=> ((driveOut_reg & $past(ocLatch_reg)) == '0))
    else $error("latched channel still driven");

  a_oc_only_on: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEnable |=> ((ocLatch_reg & ~$past(ocLatch_reg) & ~$past(driveOut_reg)) == '0))
    else $error("over-current latched on an off channel");

  a_tw_bit: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEnable && csHigh && !softClear
      |=> statusSnap_reg[DFS_STAT_TW] == ($past(thermalWarnFlag) != '0))
    else $error("thermal warning bit wrong");

  a_ot_pair_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEnable && thermalShutFlag[0] && !softClear ##1 clkEnable
      |=> driveOut_reg[1:0] == 2'b00)
    else $error("pair not shut off");

  a_ot_held: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEnable && !frameValid_reg && !softClear
      |=> (otLatch_reg & $past(otLatch_reg)) == $past(otLatch_reg))
    else $error("thermal latch dropped without frame");

  a_vcc_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEnable && logicSupplyUv |=> cmd_reg == DFS_CMD_RESET && driveOut_reg == '0)
    else $error("logic undervoltage did not clear");

  a_vs_fail: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEnable && !softClear && vsFault |=> psFail_reg && driveOut_reg == '0)
    else $error("load supply fault not handled");

  a_ov_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEnable && loadSupplyOv && !softClear && !frameValid_reg |=> $stable(cmd_reg))
    else $error("command lost in overvoltage");

  a_diag_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    (diagEn_reg & driveOut_reg) == '0)
    else $error("diagnostics on a driven channel");

  a_ps_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEnable && frameValid_reg && !vsFault && !softClear |=> !psFail_reg)
    else $error("supply-fail not cleared");

  c_frame: cover property (@(posedge clk_sys) disable iff (!resetn) frameValid_reg);
  c_oc: cover property (@(posedge clk_sys) disable iff (!resetn) ocQual != '0);
  c_ot: cover property (@(posedge clk_sys) disable iff (!resetn) otLatch_reg != '0);
  c_ol: cover property (@(posedge clk_sys) disable iff (!resetn) olLive != '0);

endmodule // dfs_driver_fault_supervisor

/* File: rtl/dfs_pkg.sv */
/*
  dfs_pkg: shared constants for the driver fault supervisor.
  Assumes a 40 MHz system clock and a 16-bit serial frame, LSB first.
*/
package dfs_pkg;

  // frame geometry
  localparam int DFS_FRAME_BITS = 16;
  localparam int DFS_CHANNELS = 8;
  localparam int DFS_PAIRS = 4;
  localparam int DFS_PWM_INPUTS = 4;

  // input (command) word fields
  localparam int DFS_CMD_EN_LSB = 0;
  localparam int DFS_CMD_OL_LSB = 8;
  localparam logic [15:0] DFS_CMD_RESET = 16'h0000;

  // output (status) word fields
  localparam int DFS_STAT_TW = 0;
  localparam int DFS_STAT_CH_LSB = 1;
  localparam int DFS_STAT_IN_LSB = 9;
  localparam int DFS_STAT_PSF = 15;
  localparam logic [15:0] DFS_STAT_RESET = 16'h0000;

  // the first parallel input steers this channel index
  localparam int DFS_PWM_FIRST_CH = 4;

  // fault filter time and its cycle count
  localparam int DFS_CLK_KHZ = 40000;
  localparam int DFS_FILTER_TIME_US = 100;
  localparam int DFS_FILT_CYCLES = (DFS_FILTER_TIME_US * DFS_CLK_KHZ) / 1000;
  localparam int DFS_FILT_W = 12;

endpackage

/* File: tb/dfs_host_spi.sv */
/*
  dfs_host_spi: behavioural host for the serial port of the fault supervisor.
  Assumes the bench calls frame() hierarchically, one frame at a time; the serial
  clock period is 125 ns and unrelated in phase to clk_sys.
*/
`timescale 1ns/1ps
module dfs_host_spi (
  output logic serialClk,
  output logic chipSelect_n,
  output logic serialIn,
  input wire logic serialOutData
);
  // link idles with chip select high and the clock standing low
  initial begin
    serialClk = 1'b0;
    chipSelect_n = 1'b1;
    serialIn = 1'b0;
  end

  // one frame, LSB first; only frames of a multiple of 16 bits are valid and can clear the latches
  task automatic frame(input logic [31:0] data, input int nBits, output logic [31:0] rx);
    rx = '0;
    #7.0;
    chipSelect_n = 1'b0;
    #31.0;
    rx[0] = serialOutData; // read before any clock edge
    for (int k = 0; k < nBits; k++) begin
      serialIn = data[k];
      #31.5;
      serialClk = 1'b1;
      #62.5;
      serialClk = 1'b0;
      #31.0;
      if (k < 31) begin
        rx[k+1] = serialOutData;
      end
    end
    chipSelect_n = 1'b1; // clock is low at this edge
    serialIn = ~serialIn; // a released line must not keep its last value
    #250.0; // chip select high long enough for the status snapshot to refresh
  endtask
endmodule // dfs_host_spi

/* File: tb/test_driver_fault_supervisor.sv */
/*
  test_driver_fault_supervisor: self-checking bench for the fault supervisor.
  Assumes dfs_pkg and the design are compiled first; the filter is shortened to 8 cycles.
*/
`timescale 1ns/1ps
module test_driver_fault_supervisor
  import dfs_pkg::*;
;
  localparam int FILT = 8;
  logic clk_sys, resetn, clkEnable, enablePin, logicSupplyUv, loadSupplyUv, loadSupplyOv;
  logic serialClk, chipSelect_n, serialIn, serialOutData, serialOutEnable, supplyFail;
  logic [3:0] parallelIn, thermalWarnFlag, thermalShutFlag;
  logic [7:0] overCurrentFlag, openLoadFlag, driveOut, diagSourceEnable, m;
  logic [15:0] cmd;
  logic [31:0] rx;
  int fail_count, total_checks, ch, p;

  dfs_driver_fault_supervisor #(.FILTER_CYCLES(FILT)) dfs_driver_fault_supervisor_i (
    .clk_sys(clk_sys), .resetn(resetn), .clkEnable(clkEnable), .serialClk(serialClk),
    .chipSelect_n(chipSelect_n), .serialIn(serialIn), .serialOutData(serialOutData),
    .serialOutEnable(serialOutEnable), .enablePin(enablePin), .parallelIn(parallelIn),
    .logicSupplyUv(logicSupplyUv), .loadSupplyUv(loadSupplyUv), .loadSupplyOv(loadSupplyOv),
    .thermalWarnFlag(thermalWarnFlag), .thermalShutFlag(thermalShutFlag),
    .overCurrentFlag(overCurrentFlag), .openLoadFlag(openLoadFlag), .driveOut(driveOut),
    .diagSourceEnable(diagSourceEnable), .supplyFail(supplyFail));

  dfs_host_spi dfs_host_spi_i (.serialClk(serialClk), .chipSelect_n(chipSelect_n),
    .serialIn(serialIn), .serialOutData(serialOutData));

  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one 16-bit frame, then time for the command to reach the outputs
  task automatic send(input logic [15:0] c);
    dfs_host_spi_i.frame({16'h0000, c}, 16, rx);
    cyc(10);
  endtask

  // serial bit ORed with the parallel inputs on the upper channels
  function automatic logic [7:0] expDrive(input logic [15:0] c, input logic [3:0] par);
    return c[7:0] | {par, 4'h0};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the tests need well under half of this
  initial begin
    #2ms;
    fail_count++;
    summarize();
  end

  initial begin
    {resetn, logicSupplyUv, loadSupplyUv, loadSupplyOv} = 4'h0;
    {parallelIn, thermalWarnFlag, thermalShutFlag} = 12'h000;
    {overCurrentFlag, openLoadFlag} = 16'h0000;
    clkEnable = 1'b1;
    enablePin = 1'b1;
    void'($urandom(38));
    cyc(8);
    resetn <= 1'b1;
    cyc(4);
    chk(16'({driveOut, diagSourceEnable}), 16'h0000, "reset outputs");
    chk(16'(supplyFail), 16'h0000, "reset supply fail");
    chk(16'(serialOutEnable), 16'h0000, "select idle");
    $display("test reset done");
    // random commands with random parallel inputs
    for (int i = 0; i < 6; i++) begin
      cmd = 16'($urandom);
      @(posedge clk_sys) parallelIn <= 4'($urandom);
      send(cmd);
      chk(16'(driveOut), 16'(expDrive(cmd, parallelIn)), "drive");
      m = cmd[15:8] & ~expDrive(cmd, parallelIn);
      chk(16'(diagSourceEnable), 16'(m), "diag sources");
    end
    @(posedge clk_sys) parallelIn <= 4'h0;
    send(16'h00F0);
    dfs_host_spi_i.frame(32'h0000_000F, 15, rx);
    cyc(10);
    chk(16'(driveOut), 16'h00F0, "short frame");
    dfs_host_spi_i.frame(32'h000F_00F0, 32, rx);
    cyc(10);
    chk(16'(driveOut), 16'h000F, "double frame");
    $display("test commands done");
    // thermal warning then shutdown of a random pair
    @(posedge clk_sys) thermalWarnFlag <= 4'h4;
    send(16'h00FF);
    chk(16'(rx[0]), 16'h0001, "warning on output");
    chk(16'(driveOut), 16'h00FF, "warning keeps drive");
    p = $urandom_range(3);
    m = 8'h03 << (2 * p);
    @(posedge clk_sys) thermalWarnFlag <= 4'h0;
    thermalShutFlag[p] <= 1'b1;
    cyc(4);
    chk(16'(driveOut), 16'(8'hFF & ~m), "pair off");
    @(posedge clk_sys) thermalShutFlag <= 4'h0;
    send(16'h00FF);
    chk(16'(driveOut), 16'(8'hFF & ~m), "shutdown held");
    chk(16'(rx[8:1]), 16'(m), "pair fault bits");
    send(16'(8'hFF & ~m));
    send(16'h00FF);
    chk(16'(driveOut), 16'h00FF, "pair restored");
    $display("test thermal done");
    // over-current: short pulse ignored, long one latches
    ch = $urandom_range(7);
    @(posedge clk_sys) overCurrentFlag[ch] <= 1'b1;
    cyc(FILT - 3);
    overCurrentFlag[ch] <= 1'b0;
    cyc(4);
    @(posedge clk_sys) overCurrentFlag[ch] <= 1'b1;
    cyc(FILT - 2);
    chk(16'(driveOut), 16'h00FF, "before filter");
    cyc(6);
    overCurrentFlag[ch] <= 1'b0;
    m = 8'h01 << ch;
    cyc(20);
    chk(16'(driveOut), 16'(8'hFF & ~m), "latched off");
    send(16'h00FF);
    chk(16'(driveOut), 16'(8'hFF & ~m), "no retry");
    chk(16'(rx[8:1]), 16'(m), "oc fault bit");
    send(16'(8'hFF & ~m));
    send(16'h00FF);
    chk(16'(driveOut), 16'h00FF, "oc cleared");
    send(16'h0000);
    @(posedge clk_sys) overCurrentFlag <= 8'hFF;
    cyc(FILT + 10);
    send(16'h0000);
    chk(16'(rx[8:1]), 16'h0000, "off channel oc");
    @(posedge clk_sys) overCurrentFlag <= 8'h00;
    $display("test over-current done");
    // load supply undervoltage then overvoltage
    for (int f = 0; f < 2; f++) begin
      send(16'hF0A5);
      @(posedge clk_sys) {loadSupplyOv, loadSupplyUv} <= 2'(1 << f);
      cyc(4);
      chk(16'({driveOut, diagSourceEnable}), 16'h0000, "supply fault off");
      chk(16'(supplyFail), 16'h0001, "supply fail set");
      send(16'hF0A5);
      chk(16'(rx[15]), 16'h0001, "serial in fault");
      chk(16'(supplyFail), 16'h0001, "no clear in fault");
      @(posedge clk_sys) {loadSupplyOv, loadSupplyUv} <= 2'b00;
      cyc(6);
      chk(16'(driveOut), 16'h00A5, "commanded again");
      chk(16'(supplyFail), 16'h0001, "fail kept");
      send(16'hF0A5);
      chk(16'(supplyFail), 16'h0000, "fail cleared");
    end
    $display("test load supply done");
    // logic supply undervoltage clears the command
    @(posedge clk_sys) logicSupplyUv <= 1'b1;
    cyc(3);
    chk(16'(driveOut), 16'h0000, "logic uv off");
    logicSupplyUv <= 1'b0;
    cyc(6);
    chk(16'(driveOut), 16'h0000, "command cleared");
    // enable pin low resets everything
    send(16'hFF0F);
    @(posedge clk_sys) enablePin <= 1'b0;
    cyc(4);
    chk(16'({driveOut, diagSourceEnable}), 16'h0000, "enable low");
    enablePin <= 1'b1;
    cyc(6);
    chk(16'(driveOut), 16'h0000, "registers reset");
    $display("test resets done");
    // open load on off channels only, live status
    send(16'hFF00);
    @(posedge clk_sys) openLoadFlag <= 8'h81;
    cyc(FILT + 8);
    send(16'hFF01);
    chk(16'(rx[8:1]), 16'h0081, "open load seen");
    cyc(FILT + 8);
    send(16'hFF01);
    chk(16'(rx[8:1]), 16'h0080, "none when on");
    chk(16'(diagSourceEnable), 16'h00FE, "sources off when on");
    @(posedge clk_sys) openLoadFlag <= 8'h00;
    cyc(FILT + 8);
    send(16'hFF01);
    chk(16'(rx[8:1]), 16'h0000, "open load unlatched");
    $display("test open load done");
    summarize();
  end
endmodule // test_driver_fault_supervisor
